// >>> core/gfrs_regs.svh
// Constants for the field reference and format select block
`ifndef GFRS_REGS_SVH
`define GFRS_REGS_SVH
`define GFRS_FMT_W 6
`define GFRS_SYNC_STAGES 2
`define GFRS_VID_CLK_COUNT 8
`define GFRS_GFX_CLK_COUNT 13
`define GFRS_VID_FMT_COUNT 35
`define GFRS_GFX_FMT_COUNT 13
`define GFRS_GFX_FMT_BASE 6'h23
`define GFRS_FMT_STABLE_NS 400
`define GFRS_CLK_NS 100
`define GFRS_FMT_STABLE_CYC ((`GFRS_FMT_STABLE_NS + `GFRS_CLK_NS - 1) / `GFRS_CLK_NS)
`define GFRS_RUN_W 8
`define GFRS_REF_MIN_RUN 4
`endif

// >>> core/gfrs_pkg.sv
// Types for the field reference and format select block
package gfrs_pkg;
  typedef enum logic [1:0] {
    GFRS_FMT_VIDEO,
    GFRS_FMT_GRAPHICS,
    GFRS_FMT_NONE
  } gfrs_fmt_class_t;
  typedef enum logic {
    GFRS_REF_SYNC,
    GFRS_REF_BLANK
  } gfrs_ref_kind_t;
endpackage

// >>> core/gfrs_core.sv
// Field reference capture and format select decode
`timescale 1ns/100ps
`include "gfrs_regs.svh"
module gfrs_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic field_ref_in,
  input wire logic line_ref_in,
  input wire logic frame_ref_in,
  input wire logic [`GFRS_FMT_W-1:0] format_select,
  input wire gfrs_pkg::gfrs_ref_kind_t ref_kind,
  output logic first_field,
  output logic field_valid,
  output logic field_tag_strobe,
  output logic line_strobe,
  output logic [`GFRS_FMT_W-1:0] format_code,
  output gfrs_pkg::gfrs_fmt_class_t format_class,
  output logic [4:0] clock_index,
  output logic [5:0] timing_index,
  output logic format_change
);
  import gfrs_pkg::*;

  localparam int NIN = 3 + `GFRS_FMT_W;
  localparam logic [2:0] STABLE_CYC = 3'(`GFRS_FMT_STABLE_CYC);
  localparam int RUN_W = `GFRS_RUN_W;
  localparam logic [RUN_W-1:0] RUN_MAX = '1;
  // Seeded so the pins settling after reset is not taken as an edge
  localparam logic [RUN_W-1:0] RUN_MIN = RUN_W'(`GFRS_REF_MIN_RUN);

  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] raw_in;
  logic fld_s, line_s, frame_s;
  logic [`GFRS_FMT_W-1:0] fmt_s;
  logic [1:0] ref_s;
  logic [1:0] ref_prev;
  logic [1:0] ref_idle;
  logic [1:0] ref_lead;
  logic [RUN_W-1:0] run_len [2];
  logic [RUN_W-1:0] last_len [2];
  logic line_lead, frame_lead;
  logic [`GFRS_FMT_W-1:0] fmt_cand;
  logic [2:0] fmt_cnt;
  logic fmt_primed;

  // Class of a select code: video codes first, graphics after
  function automatic gfrs_fmt_class_t fmt_class(input logic [`GFRS_FMT_W-1:0] c);
    if (c < 6'(`GFRS_VID_FMT_COUNT))
      return GFRS_FMT_VIDEO;
    else if (c < 6'(`GFRS_GFX_FMT_BASE + `GFRS_GFX_FMT_COUNT))
      return GFRS_FMT_GRAPHICS;
    else
      return GFRS_FMT_NONE;
  endfunction

  // Clock table index: video formats share 8 rates, graphics 13
  function automatic logic [4:0] fmt_clock(input logic [`GFRS_FMT_W-1:0] c);
    if (c < 6'(`GFRS_VID_FMT_COUNT))
      return 5'(c % 6'(`GFRS_VID_CLK_COUNT));
    else if (c < 6'(`GFRS_GFX_FMT_BASE + `GFRS_GFX_FMT_COUNT))
      return 5'(`GFRS_VID_CLK_COUNT) + 5'(c - 6'(`GFRS_GFX_FMT_BASE));
    else
      return 5'h00;
  endfunction

  assign raw_in = {field_ref_in, line_ref_in, frame_ref_in, format_select};

  // Two-flop synchroniser per input bit
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else if (ce) begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign {fld_s, line_s, frame_s, fmt_s} = sync2;

  // Bit 0 frame reference, bit 1 line reference
  assign ref_s = {line_s, frame_s};

  // Idle is the longer of the last two runs; pulses assumed shorter than gaps
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pol
      assign ref_lead[gi] = (ref_s[gi] != ref_prev[gi]) && (run_len[gi] > last_len[gi]);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ref_prev[gi] <= 1'b0;
          ref_idle[gi] <= 1'b0;
          run_len[gi] <= '0;
          last_len[gi] <= RUN_MIN;
        end else if (ce) begin
          ref_prev[gi] <= ref_s[gi];
          if (ref_s[gi] != ref_prev[gi]) begin
            ref_idle[gi] <= ref_lead[gi] ? ref_prev[gi] : ref_s[gi];
            last_len[gi] <= run_len[gi];
            run_len[gi] <= '0;
          end else if (run_len[gi] != RUN_MAX) begin
            run_len[gi] <= run_len[gi] + RUN_W'(1);
          end
        end
      end
    end
  endgenerate

  assign {line_lead, frame_lead} = ref_lead;

  // Field tag at the frame sync leading edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_field <= 1'b0;
      field_valid <= 1'b0;
      field_tag_strobe <= 1'b0;
      line_strobe <= 1'b0;
    end else if (ce) begin
      field_tag_strobe <= frame_lead;
      line_strobe <= line_lead;
      if (frame_lead) begin
        field_valid <= 1'b1;
        // High means first field for sync-based, second for blanking-based
        first_field <= (ref_kind == GFRS_REF_SYNC) ? fld_s : !fld_s;
      end
    end
  end

  // Format select must hold for a few cycles before it is adopted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fmt_cand <= '0;
      fmt_cnt <= '0;
      fmt_primed <= 1'b0;
      format_code <= '0;
      format_class <= GFRS_FMT_VIDEO;
      clock_index <= '0;
      timing_index <= '0;
      format_change <= 1'b0;
    end else if (ce) begin
      format_change <= 1'b0;
      if (fmt_s != fmt_cand) begin
        fmt_cand <= fmt_s;
        fmt_cnt <= '0;
      end else if (fmt_cnt < STABLE_CYC) begin
        fmt_cnt <= fmt_cnt + 3'h1;
      end else if (!fmt_primed || fmt_cand != format_code) begin
        fmt_primed <= 1'b1;
        format_code <= fmt_cand;
        format_class <= fmt_class(fmt_cand);
        clock_index <= fmt_clock(fmt_cand);
        timing_index <= fmt_cand;
        format_change <= 1'b1;
      end
    end
  end

  field_tag_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && frame_lead |=> field_tag_strobe && field_valid)
    else $error("field tag missing after frame edge");

  field_sense_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && frame_lead |=> first_field == (($past(ref_kind) == GFRS_REF_SYNC) ? $past(fld_s)
      : !$past(fld_s)))
    else $error("field tag sense wrong");

  field_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !frame_lead |=> $stable(first_field))
    else $error("field tag changed without frame edge");

  sync_delay_a: assert property (@(posedge clk) disable iff (!rstn)
    ce ##1 ce |=> sync2 == $past(raw_in, 2))
    else $error("synchroniser delay wrong");

  polarity_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && frame_lead |=> ref_idle[0] == $past(ref_prev[0]))
    else $error("frame idle level not learned");

  fmt_class_a: assert property (@(posedge clk) disable iff (!rstn)
    format_change |-> (format_code < 6'(`GFRS_VID_FMT_COUNT)) ==
      (format_class == GFRS_FMT_VIDEO))
    else $error("format class mismatch");

  fmt_adopt_a: assert property (@(posedge clk) disable iff (!rstn)
    format_change |-> ##1 !format_change || !ce)
    else $error("format change longer than one pulse");

  clk_range_a: assert property (@(posedge clk) disable iff (!rstn)
    clock_index < 5'(`GFRS_VID_CLK_COUNT + `GFRS_GFX_CLK_COUNT))
    else $error("clock index out of range");

  line_edge_a: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> line_strobe == $past(line_lead))
    else $error("line strobe does not follow leading edge");

  field_valid_a: assert property (@(posedge clk) disable iff (!rstn)
    field_valid |=> field_valid)
    else $error("field valid dropped");

  fmt_timing_a: assert property (@(posedge clk) disable iff (!rstn)
    format_change |-> timing_index == format_code)
    else $error("timing index differs from format code");
endmodule

// >>> verification/gfrs_src.sv
// Far-side sync source model
`timescale 1ns/100ps
module gfrs_src (
  input wire logic clk,
  output logic field_ref_in,
  output logic line_ref_in,
  output logic frame_ref_in
);
  initial begin
    field_ref_in = 1'b0;
    line_ref_in = 1'b0;
    frame_ref_in = 1'b0;
  end
  // Field level set ahead of the edge, 6-cycle pulse, 6 idle
  task automatic pulse(input logic lvl, input logic on_line);
    field_ref_in <= lvl;
    repeat (2) @(posedge clk);
    if (on_line) line_ref_in <= 1'b1;
    else frame_ref_in <= 1'b1;
    repeat (6) @(posedge clk);
    line_ref_in <= 1'b0;
    frame_ref_in <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Line sync held at one level for a number of cycles
  task automatic hold(input logic lvl, input int cyc);
    line_ref_in <= lvl;
    repeat (cyc) @(posedge clk);
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the field reference and format select block
`timescale 1ns/100ps
module tb_top;
  import gfrs_pkg::*;
  logic clk, rstn, ce, field_ref_in, line_ref_in, frame_ref_in;
  logic first_field, field_valid, field_tag_strobe, line_strobe, format_change, seen_ff;
  logic [5:0] format_select, format_code, timing_index;
  logic [4:0] clock_index;
  gfrs_fmt_class_t format_class;
  gfrs_ref_kind_t ref_kind;
  int err_total, checks, tags, lines, chg;
  gfrs_src src (.clk(clk), .field_ref_in(field_ref_in), .line_ref_in(line_ref_in),
    .frame_ref_in(frame_ref_in));
  gfrs_core dut (.clk(clk), .rstn(rstn), .ce(ce), .field_ref_in(field_ref_in),
    .line_ref_in(line_ref_in), .frame_ref_in(frame_ref_in), .format_select(format_select),
    .ref_kind(ref_kind), .first_field(first_field), .field_valid(field_valid),
    .field_tag_strobe(field_tag_strobe), .line_strobe(line_strobe),
    .format_code(format_code), .format_class(format_class), .clock_index(clock_index),
    .timing_index(timing_index), .format_change(format_change));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (field_tag_strobe === 1'b1) begin
      tags++;
      seen_ff = first_field;
    end
    if (line_strobe === 1'b1) lines++;
    if (format_change === 1'b1) chg++;
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic fmt(input logic [5:0] code, input logic [1:0] cls, input logic [4:0] ci);
    int c0;
    c0 = chg;
    format_select <= code;
    repeat (20) @(posedge clk);
    cmp("change", 8'(c0 + 1), 8'(chg));
    cmp("code", {2'h0, code}, {2'h0, format_code});
    cmp("class", {6'h0, cls}, {6'h0, format_class});
    cmp("clock", {3'h0, ci}, {3'h0, clock_index});
    cmp("timing", {2'h0, code}, {2'h0, timing_index});
  endtask
  task automatic glitch;
    int c0;
    c0 = chg;
    format_select <= 6'h15;
    repeat (2) @(posedge clk);
    format_select <= format_code;
    repeat (20) @(posedge clk);
    cmp("glitch", 8'(c0), 8'(chg));
  endtask
  task automatic field(input logic kind, input logic first);
    int t0;
    t0 = tags;
    ref_kind <= gfrs_ref_kind_t'(kind);
    src.pulse(kind ? ~first : first, 1'b0);
    cmp("tags", 8'(t0 + 1), 8'(tags));
    cmp("first", {7'h0, first}, {7'h0, seen_ff});
    cmp("valid", 8'h01, {7'h0, field_valid});
  endtask
  task automatic after_reset;
    repeat (20) @(posedge clk);
    cmp("reset adopt", 8'h01, 8'(chg));
    cmp("valid idle", 8'h00, {7'h0, field_valid});
    cmp("no strobes", 8'h00, 8'(tags + lines));
  endtask
  task automatic line_sync;
    src.pulse(1'b0, 1'b1);
    cmp("lines", 8'h01, 8'(lines));
  endtask
  task automatic inverted;
    int l0;
    src.hold(1'b1, 30);
    src.hold(1'b0, 6);
    src.hold(1'b1, 20);
    l0 = lines;
    for (int i = 1; i <= 2; i++) begin
      src.hold(1'b0, 5);
      cmp("low lead", 8'(l0 + i), 8'(lines));
      src.hold(1'b1, 20);
      cmp("low trail", 8'(l0 + i), 8'(lines));
    end
  endtask
  task automatic freeze;
    int t0;
    t0 = tags;
    ce <= 1'b0;
    src.pulse(1'b1, 1'b0);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    cmp("frozen", 8'(t0), 8'(tags));
  endtask
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    format_select = 6'h00;
    ref_kind = GFRS_REF_SYNC;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    after_reset;
    fmt(6'h22, 2'h0, 5'h02);
    fmt(6'h23, 2'h1, 5'h08);
    fmt(6'h2f, 2'h1, 5'h14);
    fmt(6'h30, 2'h2, 5'h00);
    fmt(6'h07, 2'h0, 5'h07);
    glitch;
    for (int k = 0; k < 4; k++) field(k[1], k[0]);
    line_sync;
    inverted;
    freeze;
    conclude;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude;
  end
endmodule
